/* bench/sensor_front_end.sv */
/*
  Front-end model: sends samples, frame pulses and the charger pin level.
  Assumes one bench process calls its tasks, all timed on sys_clk.
*/
`timescale 1ns/1ps
module sensor_front_end (
  input wire logic sys_clk,
  output logic charger_noise_input,
  output logic frame_start,
  output logic frame_end,
  output logic sample_valid,
  output logic [7:0] sample_point,
  output logic [1:0] sample_kind,
  output logic [11:0] sample_value,
  output logic [11:0] sample_noise,
  output logic sample_stylus,
  output logic [11:0] sample_x,
  output logic [11:0] sample_y,
  output logic [11:0] sample_area
);
  // Quiet lines at time zero.
  initial begin
    {charger_noise_input, frame_start, frame_end, sample_valid, sample_stylus} = 5'h00;
    {sample_point, sample_kind} = 10'h000;
    {sample_value, sample_noise, sample_x, sample_y, sample_area} = 60'h0;
  end

  // A charger holds the pin as a level; it moves only after an edge.
  task automatic set_pin(input logic b);
    @(posedge sys_clk);
    charger_noise_input <= b;
  endtask

  // One sample held for one cycle; then the point, value and noise lines show its inverse,
  // so a design that reads them late cannot see a stale match.
  task automatic send(input logic [7:0] p, input logic [1:0] k, input logic [11:0] v,
                      input logic [11:0] n, input logic s, input logic [11:0] x,
                      input logic [11:0] y, input logic [11:0] a);
    @(posedge sys_clk);
    sample_valid <= 1'b1;
    {sample_point, sample_kind, sample_stylus} <= {p, k, s};
    {sample_value, sample_noise, sample_x, sample_y, sample_area} <= {v, n, x, y, a};
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    {sample_point, sample_value, sample_noise} <= {~p, ~v, ~n};
  endtask

  // One-cycle frame pulse: start when last is 0, end when 1.
  task automatic frame(input logic last);
    @(posedge sys_clk);
    frame_start <= !last;
    frame_end <= last;
    @(posedge sys_clk);
    frame_start <= 1'b0;
    frame_end <= 1'b0;
  endtask
endmodule

/* bench/touch_detection_postprocess_tb_top.sv */
/*
  Self-checking bench: register port, integrator, noise handling,
  suppression, frame limit and interrupt of the touch block.
  Assumes the package, the design and the front-end model are compiled first.
*/
`timescale 1ns/1ps
module touch_detection_postprocess_tb_top;
  logic sys_clk, rstn, wr, rd, charger_noise_input, frame_start, frame_end;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic sample_valid, sample_stylus, res_valid, res_touched, res_suppressed;
  logic [7:0] sample_point, res_point;
  logic [1:0] sample_kind;
  logic [11:0] sample_value, sample_noise, sample_x, sample_y, sample_area;
  logic frame_done, frame_suppress_all, charger_active, dual_x_drive, irq;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] lfsr = 32'h787c6f82;
  logic [6:0] ctrl;
  logic pin;
  logic [7:0] cnt [256];
  // Fixed configuration; every expectation is derived from these.
  localparam logic [11:0] FTHR = 12'd100, STHR = 12'd40, OLIM = 12'd400, CADD = 12'd30;
  localparam logic [11:0] BORDER = 12'd50, ALIM = 12'd300, XMAX = 12'd1000, YMAX = 12'd800;
  localparam logic [11:0] XC [4] = '{12'd49, 12'd50, 12'd950, 12'd951};
  localparam logic [11:0] YC [4] = '{12'd49, 12'd50, 12'd750, 12'd751};

  touch_postproc i_dut (.sys_clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .charger_noise_input, .frame_start, .frame_end, .sample_valid, .sample_point,
    .sample_kind, .sample_value, .sample_noise, .sample_stylus, .sample_x, .sample_y,
    .sample_area, .res_valid, .res_point, .res_touched, .res_suppressed, .frame_done,
    .frame_suppress_all, .charger_active, .dual_x_drive, .irq);
  sensor_front_end i_fe (.sys_clk, .charger_noise_input, .frame_start, .frame_end,
    .sample_valid, .sample_point, .sample_kind, .sample_value, .sample_noise,
    .sample_stylus, .sample_x, .sample_y, .sample_area);

  // 50 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0);
  endfunction

  // Values cluster round the finger, noisy-finger, outlier and stylus edges.
  function automatic logic [11:0] pick_val(input logic [31:0] r);
    logic [11:0] base [4] = '{12'd95, 12'd126, 12'd397, 12'd36};
    return base[r[1:0]] + {9'h0, r[10:8]};
  endfunction

  // Reference integrator and suppression, updating the per-point counters.
  function automatic void model(input logic [7:0] p, input logic [1:0] k,
      input logic [11:0] v, n, input logic s, input logic [11:0] x, y, a,
      output logic disc, tch, sup);
    logic [12:0] thr;
    logic [11:0] sig;
    logic [7:0] lm;
    logic chg, conf, grip;
    chg = ctrl[0] | pin;
    thr = {1'b0, s ? STHR : FTHR} + (chg ? {1'b0, CADD} : 13'h0);
    sig = ctrl[2] ? ((v > n) ? v - n : 12'h0) : v;
    disc = ctrl[1] && chg && !ctrl[2] && sig > OLIM;
    if (!disc) cnt[p] = ({1'b0, sig} > thr) ? cnt[p] + {7'h0, cnt[p] != 8'hff} : 8'h00;
    lm = (k == 2'd3) ? 8'd0 : 8'd3 - {6'h0, k};
    conf = lm != 8'd0 && cnt[p] >= lm;
    grip = ctrl[4] && (x < BORDER || x + BORDER > XMAX || y < BORDER || y + BORDER > YMAX);
    sup = conf && k == 2'd0 && (grip || (ctrl[5] && a > ALIM)); // Screen points only.
    tch = conf && !sup;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic do_sample(input logic [7:0] p, input logic [1:0] k, input logic [11:0] v,
      n, input logic s, input logic [11:0] x, y, a);
    logic disc, tch, sup;
    model(p, k, v, n, s, x, y, a, disc, tch, sup);
    i_fe.send(p, k, v, n, s, x, y, a);
    #1 check("res_valid", res_valid, !disc);
    if (!disc) begin
      check("res_point", res_point, p);
      check("res_touched", res_touched, tch);
      check("res_suppressed", res_suppressed, sup);
    end
  endtask

  task automatic results();
    if (mismatches == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Cuts a hang short; the run needs only about 1200 cycles.
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    {addr, wdata, wr, rd, ctrl, pin} = '0;
    rstn = 1'b0;
    foreach (cnt[i]) cnt[i] = 8'h00;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    // Everything reads zero after reset, the unmapped index too.
    for (int a = 0; a < 11; a++) begin
      rd_reg(8'(a), rv);
      check("reset_reg", rv, 32'h0);
    end
    check("reset_out", {charger_active, dual_x_drive, irq}, 32'h0);
    wr_reg(touch_pkg::REG_LIMITS, 32'h0001_0203);
    wr_reg(touch_pkg::REG_THRESH, {8'h00, STHR, FTHR});
    wr_reg(touch_pkg::REG_CHARGER, {8'h00, CADD, OLIM});
    wr_reg(touch_pkg::REG_SUPPRESS, {8'h02, ALIM, BORDER});
    wr_reg(touch_pkg::REG_SCREEN, {8'h00, YMAX, XMAX});
    rd_reg(touch_pkg::REG_THRESH, rv);
    check("thresh", rv, {8'h00, STHR, FTHR});
    // Random batches: a control word and pin level, then a burst of samples.
    for (int b = 0; b < 30; b++) begin
      lfsr = next_rand(lfsr);
      ctrl = {1'b0, lfsr[5:0]};
      pin = lfsr[6];
      wr_reg(touch_pkg::REG_CTRL, {25'h0, ctrl});
      i_fe.set_pin(pin);
      repeat (2) @(posedge sys_clk);
      #1 check("charger_active", charger_active, pin | ctrl[0]);
      check("dual_x_drive", dual_x_drive, ctrl[3]);
      for (int i = 0; i < 16; i++) begin
        lfsr = next_rand(lfsr);
        do_sample({5'h0, lfsr[26:24]}, lfsr[25:24], pick_val(lfsr),
          lfsr[16] ? 12'd600 : {8'h0, lfsr[15:12]}, lfsr[23],
          lfsr[31] ? XC[lfsr[21:20]] : {2'b0, lfsr[9:0]},
          lfsr[30] ? YC[lfsr[19:18]] : {3'b0, lfsr[18:10]}, lfsr[22] ? 12'd500 : 12'd100);
      end
    end
    // Interrupt masked, then enabled, then cleared by writing ones.
    wr_reg(touch_pkg::REG_IRQ_EN, 32'h0);
    rd_reg(touch_pkg::REG_STATUS, rv);
    check("status_touch", rv[0], 1'b1);
    check("irq_masked", irq, 1'b0);
    wr_reg(touch_pkg::REG_IRQ_EN, 32'h1);
    rd_reg(touch_pkg::REG_IRQ_EN, rv);
    check("irq_en", rv, 32'h1);
    check("irq_on", irq, 1'b1);
    wr_reg(touch_pkg::REG_CLEAR, 32'h7);
    rd_reg(touch_pkg::REG_STATUS, rv);
    check("status_clear", rv, 32'h0);
    check("irq_off", irq, 1'b0);
    // Frame limit of two: two new touches pass, three trip suppression.
    ctrl = 7'h40;
    pin = 1'b0;
    wr_reg(touch_pkg::REG_CTRL, 32'h40);
    i_fe.set_pin(1'b0);
    for (int n = 2; n < 4; n++) begin
      i_fe.frame(1'b0);
      for (int i = 0; i < n; i++) begin
        do_sample(8'(16 + 4 * n + i), 2'd2, 12'd500, 12'd0, 1'b0, 12'd500, 12'd400, 12'd100);
      end
      i_fe.frame(1'b1);
      #1 check("frame_done", frame_done, 1'b1);
      check("suppress_all", frame_suppress_all, n > 2);
    end
    rd_reg(touch_pkg::REG_STATUS, rv);
    check("status_max", rv[1], 1'b1);
    check("status_all", rv, 32'h3);
    rd_reg(touch_pkg::REG_STATE, rv);
    check("state", rv, 32'h3);
    // The host noise bit alone must raise the noise event.
    wr_reg(touch_pkg::REG_CTRL, 32'h1);
    repeat (2) @(posedge sys_clk);
    rd_reg(touch_pkg::REG_STATUS, rv);
    check("status_noise", rv[2], 1'b1);
    results();
  end
endmodule

/* hw/touch_pkg.sv */
/*
  Shared constants for the touch qualification block: register indices,
  field positions, reset values and point kinds.
  Assumes a 50 MHz system clock and a word-indexed register port.
*/
package touch_pkg;

  // Register indices on the plain register port.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LIMITS = 8'h01;
  localparam logic [7:0] REG_THRESH = 8'h02;
  localparam logic [7:0] REG_CHARGER = 8'h03;
  localparam logic [7:0] REG_SUPPRESS = 8'h04;
  localparam logic [7:0] REG_SCREEN = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam logic [7:0] REG_CLEAR = 8'h07;
  localparam logic [7:0] REG_IRQ_EN = 8'h08;
  localparam logic [7:0] REG_STATE = 8'h09;

  // Control field positions.
  localparam int CTRL_HOST_NOISE = 0;
  localparam int CTRL_OUTLIER_EN = 1;
  localparam int CTRL_DISPLAY_EN = 2;
  localparam int CTRL_DUAL_X = 3;
  localparam int CTRL_GRIP_EN = 4;
  localparam int CTRL_LARGE_EN = 5;
  localparam int CTRL_MAX_EN = 6;
  localparam int CTRL_W = 7;

  // Status and interrupt bit positions.
  localparam int EV_NEW_TOUCH = 0;
  localparam int EV_MAX_SUPPRESS = 1;
  localparam int EV_NOISE_ON = 2;
  localparam int EV_W = 3;

  // Every configuration field resets to zero, which leaves its function off.
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  // Sizes.
  localparam int POINTS = 256;
  localparam int SAMPLE_W = 12;
  localparam int COUNT_W = 8;

  // Sensing point kinds, each with its own integration limit.
  typedef enum logic [1:0] {
    KIND_SCREEN,
    KIND_KEY,
    KIND_PROX
  } point_kind_t;

endpackage

/* hw/touch_postproc.sv */
/*
  Touch qualification after acquisition: noise handling on each converted
  sample, the per-point detection integrator, edge and large-area
  suppression, a per-frame touch count with maximum-touch suppression,
  the register port and the interrupt.
  Assumes the front end delivers one sample per cycle at most, framed by
  one-cycle start and end pulses, all synchronous to sys_clk.
*/
// How it works
// - A point's counter steps up on each acquisition above its threshold.
// - A point is declared touched once its counter reaches the integration limit.
// - One acquisition at or below threshold clears the counter to zero.
// - Screen, key and proximity points each have their own integration limit.
// - When enabled and charger noise is present, samples above the outlier limit are discarded unprocessed.
// - Noise suppression engages from the charger pin or a host-written bit.
// - While charger noise is present the detection threshold is raised.
// - A control bit selects paired X-line bursts for close-pitch matrices.
// - When enabled, measured display noise is subtracted from each sample.
// - With display cancelling on, the outlier rejector is never applied.
// - Display cancelling and the charger threshold raise can act on the same sample.
// - Stylus samples are compared against their own threshold.
// - Touches inside the configured border are suppressed; centre ones pass.
// - Large-area contacts are suppressed when touch suppression is on.
// - Above the maximum touch count in a frame, all touches are suppressed.
// - All logic runs on the one internal clock sys_clk.
// - Every configuration field resets to zero, which disables its function.
`timescale 1ns/1ps
module touch_postproc (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic charger_noise_input,
  input wire logic frame_start,
  input wire logic frame_end,
  input wire logic sample_valid,
  input wire logic [7:0] sample_point,
  input wire logic [1:0] sample_kind,
  input wire logic [11:0] sample_value,
  input wire logic [11:0] sample_noise,
  input wire logic sample_stylus,
  input wire logic [11:0] sample_x,
  input wire logic [11:0] sample_y,
  input wire logic [11:0] sample_area,
  output logic res_valid,
  output logic [7:0] res_point,
  output logic res_touched,
  output logic res_suppressed,
  output logic frame_done,
  output logic frame_suppress_all,
  output logic charger_active,
  output logic dual_x_drive,
  output logic irq
);

  // Configuration held for software.
  logic [touch_pkg::CTRL_W-1:0] ctrl;
  logic [31:0] limits;
  logic [31:0] thresh;
  logic [31:0] charger_cfg;
  logic [31:0] suppress_cfg;
  logic [31:0] screen_cfg;
  logic [touch_pkg::EV_W-1:0] status;
  logic [touch_pkg::EV_W-1:0] irq_en;
  logic [7:0] frame_touches;
  logic [7:0] last_touches;
  logic noise_prev;

  // Per-point integrator state: counter and the touched flag of last time.
  logic [touch_pkg::COUNT_W-1:0] count_mem [0:touch_pkg::POINTS-1];
  logic touched_mem [0:touch_pkg::POINTS-1];

  // Fields of the configuration words.
  wire logic [7:0] lim_screen = limits[7:0];
  wire logic [7:0] lim_key = limits[15:8];
  wire logic [7:0] lim_prox = limits[23:16];
  wire logic [11:0] thr_finger = thresh[11:0];
  wire logic [11:0] thr_stylus = thresh[23:12];
  wire logic [11:0] outlier_limit = charger_cfg[11:0];
  wire logic [11:0] noise_thr_add = charger_cfg[23:12];
  wire logic [11:0] border = suppress_cfg[11:0];
  wire logic [11:0] area_limit = suppress_cfg[23:12];
  wire logic [7:0] max_touches = suppress_cfg[31:24];
  wire logic [11:0] screen_x_max = screen_cfg[11:0];
  wire logic [11:0] screen_y_max = screen_cfg[23:12];

  // Picks the integration limit for a point kind; unused code gives zero.
  function automatic logic [7:0] kind_limit(input logic [1:0] kind,
                                            input logic [7:0] ls,
                                            input logic [7:0] lk,
                                            input logic [7:0] lp);
    logic [7:0] r;
    r = 8'h00;
    if (kind == touch_pkg::KIND_SCREEN) begin
      r = ls;
    end else if (kind == touch_pkg::KIND_KEY) begin
      r = lk;
    end else if (kind == touch_pkg::KIND_PROX) begin
      r = lp;
    end
    return r;
  endfunction

  // True when a coordinate lies inside the border strip at either end.
  function automatic logic in_border(input logic [11:0] pos,
                                     input logic [11:0] span,
                                     input logic [11:0] width);
    logic [12:0] far_edge;
    far_edge = {1'b0, pos} + {1'b0, width};
    return (pos < width) || (far_edge > {1'b0, span});
  endfunction

  // Noise conditions. The two noise mechanisms are separate paths, so both
  // may be active on the same sample.
  wire logic noise_now = charger_noise_input | ctrl[touch_pkg::CTRL_HOST_NOISE];
  wire logic display_on = ctrl[touch_pkg::CTRL_DISPLAY_EN];
  wire logic outlier_on = ctrl[touch_pkg::CTRL_OUTLIER_EN] && charger_active
                          && !display_on;

  // Display noise is subtracted first and saturates at zero.
  wire logic [11:0] cancelled = (sample_value > sample_noise) ?
                                12'(sample_value - sample_noise) : 12'h000;
  wire logic [11:0] signal = display_on ? cancelled : sample_value;
  wire logic reject = outlier_on && (signal > outlier_limit);
  wire logic accept = sample_valid && !reject;

  // Threshold: stylus or finger base, raised while charger noise is present.
  wire logic [11:0] base_thr = sample_stylus ? thr_stylus : thr_finger;
  wire logic [12:0] raised_thr = {1'b0, base_thr} + {1'b0, noise_thr_add};
  wire logic [12:0] eff_thr = charger_active ? raised_thr : {1'b0, base_thr};
  wire logic over = {1'b0, signal} > eff_thr;

  // Integrator step. A zero limit means the object is unconfigured and never
  // reports, which keeps a freshly reset part silent.
  wire logic [7:0] cur_count = count_mem[sample_point];
  wire logic [7:0] lim = kind_limit(sample_kind, lim_screen, lim_key, lim_prox);
  wire logic [7:0] next_count = !over ? 8'h00 :
                                (cur_count == 8'hff) ? 8'hff : 8'(cur_count + 8'h01);
  wire logic next_touched = over && (lim != 8'h00) && (next_count >= lim);
  wire logic new_touch = accept && next_touched && !touched_mem[sample_point];

  // Suppression of confirmed touches. Border and large-area checks only
  // apply to screen points; keys and proximity have no geometry.
  wire logic is_screen = sample_kind == touch_pkg::KIND_SCREEN;
  wire logic grip_hit = ctrl[touch_pkg::CTRL_GRIP_EN] && is_screen
                        && (in_border(sample_x, screen_x_max, border)
                            || in_border(sample_y, screen_y_max, border));
  wire logic large_hit = ctrl[touch_pkg::CTRL_LARGE_EN] && is_screen
                         && (area_limit != 12'h000) && (sample_area > area_limit);
  wire logic suppress = grip_hit || large_hit;
  wire logic counts = accept && next_touched && !suppress;
  wire logic [7:0] next_frame_touches = frame_start ? 8'h00 : frame_touches;
  wire logic [7:0] frame_total = (counts && next_frame_touches != 8'hff) ?
                                 8'(next_frame_touches + 8'h01) : next_frame_touches;
  wire logic max_hit = frame_end && ctrl[touch_pkg::CTRL_MAX_EN]
                       && (frame_total > max_touches);

  // Register decode.
  wire logic wr_ctrl = wr && (addr == touch_pkg::REG_CTRL);
  wire logic wr_clear = wr && (addr == touch_pkg::REG_CLEAR);
  wire logic noise_rise = charger_active && !noise_prev;
  wire logic [touch_pkg::EV_W-1:0] events = {noise_rise, max_hit, new_touch};
  wire logic [touch_pkg::EV_W-1:0] clear_bits = wr_clear ? wdata[touch_pkg::EV_W-1:0] :
                                                '0;
  wire logic [touch_pkg::EV_W-1:0] next_status = (status & ~clear_bits) | events;
  wire logic [31:0] read_mux =
    (addr == touch_pkg::REG_CTRL) ? {25'h0000000, ctrl} :
    (addr == touch_pkg::REG_LIMITS) ? limits :
    (addr == touch_pkg::REG_THRESH) ? thresh :
    (addr == touch_pkg::REG_CHARGER) ? charger_cfg :
    (addr == touch_pkg::REG_SUPPRESS) ? suppress_cfg :
    (addr == touch_pkg::REG_SCREEN) ? screen_cfg :
    (addr == touch_pkg::REG_STATUS) ? {29'h00000000, status} :
    (addr == touch_pkg::REG_IRQ_EN) ? {29'h00000000, irq_en} :
    (addr == touch_pkg::REG_STATE) ? {15'h0000, charger_active, frame_touches,
                                      last_touches} :
    32'h0000_0000;

  // Configuration registers; all reset to the all-zero safe value.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= touch_pkg::CFG_RESET[touch_pkg::CTRL_W-1:0];
      limits <= touch_pkg::CFG_RESET;
      thresh <= touch_pkg::CFG_RESET;
      charger_cfg <= touch_pkg::CFG_RESET;
      suppress_cfg <= touch_pkg::CFG_RESET;
      screen_cfg <= touch_pkg::CFG_RESET;
      irq_en <= '0;
    end else if (wr) begin
      if (wr_ctrl) ctrl <= wdata[touch_pkg::CTRL_W-1:0];
      if (addr == touch_pkg::REG_LIMITS) limits <= wdata;
      if (addr == touch_pkg::REG_THRESH) thresh <= wdata;
      if (addr == touch_pkg::REG_CHARGER) charger_cfg <= wdata;
      if (addr == touch_pkg::REG_SUPPRESS) suppress_cfg <= wdata;
      if (addr == touch_pkg::REG_SCREEN) screen_cfg <= wdata;
      if (addr == touch_pkg::REG_IRQ_EN) irq_en <= wdata[touch_pkg::EV_W-1:0];
    end
  end

  // Status, read data, interrupt and the two level outputs. Events set over
  // a simultaneous clear, so nothing that lands on a clear write is lost.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      status <= '0;
      rdata <= 32'h0000_0000;
      irq <= 1'b0;
      charger_active <= 1'b0;
      noise_prev <= 1'b0;
      dual_x_drive <= 1'b0;
    end else begin
      status <= next_status;
      rdata <= rd ? read_mux : 32'h0000_0000;
      irq <= |(next_status & irq_en);
      charger_active <= noise_now;
      noise_prev <= charger_active;
      dual_x_drive <= ctrl[touch_pkg::CTRL_DUAL_X];
    end
  end

  // Integrator memory. A rejected sample leaves its point untouched, as if
  // that conversion had never arrived.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < touch_pkg::POINTS; i++) begin
        count_mem[i] <= 8'h00;
        touched_mem[i] <= 1'b0;
      end
    end else if (accept) begin
      count_mem[sample_point] <= next_count;
      touched_mem[sample_point] <= next_touched;
    end
  end

  // Per-sample result and per-frame summary.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      res_valid <= 1'b0;
      res_point <= 8'h00;
      res_touched <= 1'b0;
      res_suppressed <= 1'b0;
      frame_touches <= 8'h00;
      last_touches <= 8'h00;
      frame_done <= 1'b0;
      frame_suppress_all <= 1'b0;
    end else begin
      res_valid <= accept;
      res_point <= sample_point;
      res_touched <= accept && next_touched && !suppress;
      res_suppressed <= accept && next_touched && suppress;
      frame_touches <= frame_end ? 8'h00 : frame_total;
      frame_done <= frame_end;
      frame_suppress_all <= max_hit;
      if (frame_end) last_touches <= frame_total;
    end
  end

  // Checks on the datapath and the interrupt.
  sequence sample_in_s;
    sample_valid && !reject;
  endsequence

  sequence sample_out_s;
    res_valid && (res_point == $past(sample_point));
  endsequence

  property result_follows_p;
    @(posedge sys_clk) disable iff (!rstn) sample_in_s |=> sample_out_s;
  endproperty
  result_follow_a: assert property (result_follows_p)
    else $error("accepted sample gave no result next cycle");

  count_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && !over) |=> (count_mem[$past(sample_point)] == 8'h00) && !res_touched)
    else $error("counter not cleared after low sample");

  count_step_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && over && cur_count < 8'hff) |=>
      count_mem[$past(sample_point)] == 8'($past(cur_count) + 8'h01))
    else $error("counter did not step on high sample");

  touch_limit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    res_touched |-> ($past(next_count) >= $past(lim)) && ($past(lim) != 8'h00))
    else $error("touch reported before limit reached");

  outlier_drop_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (sample_valid && outlier_on && signal > outlier_limit) |=> !res_valid)
    else $error("outlier sample was processed");

  display_blocks_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    display_on |-> !reject)
    else $error("outlier rejector active with display cancelling");

  noise_or_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (charger_noise_input || ctrl[touch_pkg::CTRL_HOST_NOISE]) |=> charger_active)
    else $error("noise source did not engage suppression");

  max_touch_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (frame_end && ctrl[touch_pkg::CTRL_MAX_EN] && frame_total > max_touches)
      |=> frame_suppress_all && frame_done)
    else $error("maximum touch suppression missed");

  grip_edge_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && next_touched && grip_hit) |=> res_suppressed && !res_touched)
    else $error("border touch not suppressed");

  irq_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (new_touch && irq_en[touch_pkg::EV_NEW_TOUCH]) |=> irq && status[touch_pkg::EV_NEW_TOUCH])
    else $error("new touch did not raise the interrupt");

  // A zero limit keeps the object silent.
  zero_limit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && lim == 8'h00) |=> !res_touched && !res_suppressed)
    else $error("touch with zero limit");

  // A key point waits for its own limit.
  key_limit_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && sample_kind == 2'd1 && next_count < lim_key) |=> !res_touched)
    else $error("key confirmed before its limit");

  // A fully cancelled sample has nothing left to detect.
  cancel_floor_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && display_on && sample_value <= sample_noise) |=> !res_touched)
    else $error("cancelled sample gave a touch");

  // Under charger noise the raised threshold applies, not the base one.
  raised_thr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && charger_active && {1'b0, signal} <= raised_thr) |=> !res_touched)
    else $error("touch below raised threshold");

  // A stylus on a one-shot object confirms above its own threshold.
  stylus_thr_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && sample_stylus && !charger_active && signal > thr_stylus
     && lim == 8'h01 && !suppress) |=> res_touched)
    else $error("stylus touch not confirmed");

  // Large screen contacts are held back.
  large_area_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (accept && next_touched && large_hit) |=> res_suppressed && !res_touched)
    else $error("large contact not suppressed");

  // Without the enable no frame is ever suppressed.
  max_quiet_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (frame_end && !ctrl[touch_pkg::CTRL_MAX_EN]) |=> frame_done && !frame_suppress_all)
    else $error("frame suppressed while disabled");

  // With both sources gone suppression stands down.
  noise_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(charger_noise_input || ctrl[touch_pkg::CTRL_HOST_NOISE]) |=> !charger_active)
    else $error("suppression on without a source");

  // The burst mode output follows its control bit.
  dual_x_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> dual_x_drive == $past(ctrl[touch_pkg::CTRL_DUAL_X]))
    else $error("paired burst output stale");

  // An event that meets a clear write must survive it.
  set_wins_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    (|events) |=> (status & $past(events)) == $past(events))
    else $error("event lost to a clear");

  // The interrupt is the level of the enabled status bits.
  irq_follow_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1 |=> irq == |(status & $past(irq_en)))
    else $error("interrupt level wrong");

  // Read data stand only after a read strobe.
  rdata_idle_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    !rd |=> rdata == 32'h0000_0000)
    else $error("read data without a strobe");

endmodule
